//--- verilog/lld_pkg.sv
// Shared constants for the local dimming PWM block.
package lld_pkg;

  localparam int NUM_CH = 12;
  localparam int GAIN_W = 7;
  localparam int THR_W  = 16;
  localparam int SUB_W  = 9;
  localparam int STG_W  = 5;

  localparam logic [GAIN_W-1:0] STEP_MAX   = 7'h7F;
  localparam logic [GAIN_W-1:0] STEP_LAST1 = 7'h7E;
  localparam int                STEPS      = 128;

  // Clock rates and the internal oscillator that paces the dimming counter.
  localparam int MCLK_PERIOD_PS = 8000;
  localparam int OSC_PERIOD_NS  = 303;
  localparam int OSC_DIV        = (OSC_PERIOD_NS * 1000) / MCLK_PERIOD_PS;

  // Longest PWM periods and the oscillator ticks spent in each counter step.
  localparam int PERIOD_SHORT_NS = 5000000;
  localparam int PERIOD_LONG_NS  = 10000000;
  localparam logic [SUB_W-1:0] SUB_SHORT = SUB_W'(PERIOD_SHORT_NS / (STEPS * OSC_PERIOD_NS));
  localparam logic [SUB_W-1:0] SUB_LONG  = SUB_W'(PERIOD_LONG_NS / (STEPS * OSC_PERIOD_NS));

  // Ratio between neighbouring dimming steps, as a Q16 fraction.
  localparam int          ALPHA_X10000 = 9471;
  localparam logic [15:0] ALPHA_Q16    = 16'((ALPHA_X10000 * 65536 + 5000) / 10000);

  // Comparator trip points that drive the two thermal inputs.
  localparam int TEMP_WARN_C = 140;
  localparam int TEMP_SHUT_C = 170;

  // Register direct addresses.
  localparam logic [7:0] ADDR_CONF_ONE    = 8'h00;
  localparam logic [7:0] ADDR_CONF_TWO    = 8'h01;
  localparam logic [7:0] ADDR_UPPER_FAULT = 8'h03;
  localparam logic [7:0] ADDR_GAIN_FIRST  = 8'h05;
  localparam logic [7:0] ADDR_GAIN_LAST   = 8'h10;

  // Field positions.
  localparam int CONF_BUS_MODE_BIT = 7;
  localparam int CONF_FLAG_HI      = 6;
  localparam int CONF_FLAG_LO      = 5;
  localparam int CONF_DIM_EN_BIT   = 4;
  localparam int CONF_CH_HI        = 3;
  localparam int UPPER_PERIOD_BIT  = 7;
  localparam int GAIN_PWM_ON_BIT   = 7;
  localparam int STATUS_T_ALERT    = 3;
  localparam int STATUS_T_FAIL     = 2;

  localparam logic [7:0]        CONF_RESET = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 7'h00;

  // Oscillator tick at which each channel turns on, counted from channel 0.
  localparam logic [NUM_CH-1:0][STG_W-1:0] STAGGER_AT = {
    5'h12, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D,
    5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [STG_W-1:0] STAGGER_END = 5'h12;

endpackage : lld_pkg

//--- verilog/lld_tick_gen.sv
// Divider that turns the system clock into internal oscillator ticks.
`timescale 1ns/1ps
module lld_tick_gen #(
  parameter int DIV = lld_pkg::OSC_DIV
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  output logic      tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= ZERO;
      tick  <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= ZERO;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + ONE;
      tick  <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
    tick |-> ##1 (!tick) [*8]) else $error("oscillator ticks too close");

endmodule : lld_tick_gen

//--- verilog/lld_curve_engine.sv
// Serial engine that turns a dimming step into an exponential on-time.
`timescale 1ns/1ps
module lld_curve_engine #(
  parameter int THR_W  = lld_pkg::THR_W,
  parameter int GAIN_W = lld_pkg::GAIN_W
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              start,
  input  wire logic [GAIN_W-1:0] gain,
  input  wire logic [THR_W-1:0]  full,
  output logic                   ready,
  output logic                   done,
  output logic [THR_W-1:0]       result
);

  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_DONE} lld_eng_e;

  localparam logic [GAIN_W-1:0] ONE = GAIN_W'(1);

  lld_eng_e          state_q;
  logic [THR_W-1:0]  acc_q;
  logic [GAIN_W-1:0] left_q;

  // One multiply per cycle keeps the area to a single multiplier shared by all channels.
  function automatic logic [THR_W-1:0] lldScale(input logic [THR_W-1:0] v);
    logic [THR_W+15:0] p;
    p = v * lld_pkg::ALPHA_Q16;
    return p[THR_W+15:16];
  endfunction : lldScale

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ENG_IDLE;
      acc_q   <= '0;
      left_q  <= '0;
    end else begin
      case (state_q)
        ENG_IDLE: begin
          if (start) begin
            acc_q   <= full;
            left_q  <= lld_pkg::STEP_MAX - gain;
            state_q <= ENG_RUN;
          end
        end
        ENG_RUN: begin
          if (left_q == '0) begin
            state_q <= ENG_DONE;
          end else begin
            acc_q  <= lldScale(acc_q);
            left_q <= left_q - ONE;
          end
        end
        default: begin
          state_q <= ENG_IDLE;
        end
      endcase
    end
  end

  assign ready  = (state_q == ENG_IDLE);
  assign done   = (state_q == ENG_DONE);
  assign result = acc_q;

  a_engine_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    (start && ready) |-> ##[2:129] done) else $error("on-time not computed in time");

  a_top_step: assert property (@(posedge mclk) disable iff (!reset_n)
    (start && ready && gain == lld_pkg::STEP_MAX) |-> ##2 (done && result == $past(full, 2)))
    else $error("top step is not full period");

endmodule : lld_curve_engine

//--- verilog/lld_dimming.sv
// Twelve-channel local dimming PWM with staggered turn-on and thermal protection.
`timescale 1ns/1ps
module lld_dimming #(
  parameter int NUM_CH  = lld_pkg::NUM_CH,
  parameter int OSC_DIV = lld_pkg::OSC_DIV
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              regWrite,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regData,
  input  wire logic              statusClear,
  input  wire logic              tempWarnRaw,
  input  wire logic              tempShutRaw,
  output logic      [NUM_CH-1:0] chanOut,
  output logic                   faultFlagPin,
  output logic      [7:0]        faultStatus,
  output logic      [1:0]        flagMode,
  output logic      [6:0]        dimCount
);

  localparam int GW = lld_pkg::GAIN_W;
  localparam int TW = lld_pkg::THR_W;
  localparam int SW = lld_pkg::SUB_W;
  localparam logic [SW-1:0] SUB_ONE  = SW'(1);
  localparam logic [GW-1:0] STEP_ONE = GW'(1);
  localparam int GSW = lld_pkg::STG_W;
  localparam logic [GSW-1:0] STG_ONE = GSW'(1);
  localparam logic [3:0] CH_ONE  = 4'h1;
  localparam logic [3:0] CH_LAST = 4'(NUM_CH - 1);

  // Thermal comparator outputs arrive from the analog side, unrelated to mclk.
  logic warnMeta_q;
  logic warnSync_q;
  logic shutMeta_q;
  logic shutSync_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      warnMeta_q <= 1'b0;
      warnSync_q <= 1'b0;
      shutMeta_q <= 1'b0;
      shutSync_q <= 1'b0;
    end else begin
      warnMeta_q <= tempWarnRaw;
      warnSync_q <= warnMeta_q;
      shutMeta_q <= tempShutRaw;
      shutSync_q <= shutMeta_q;
    end
  end

  // Register write port.
  logic                     busModeSel_q;
  logic                     dimEn_q;
  logic [1:0]               flagMode_q;
  logic [NUM_CH-1:0]        chanEn_q;
  logic                     longPeriod_q;
  logic [NUM_CH-1:0]        pwmOn_q;
  logic [NUM_CH-1:0][GW-1:0] gainPend_q;
  logic [7:0]               gainIdx;

  assign gainIdx = regAddr - lld_pkg::ADDR_GAIN_FIRST;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busModeSel_q <= lld_pkg::CONF_RESET[lld_pkg::CONF_BUS_MODE_BIT];
      dimEn_q      <= lld_pkg::CONF_RESET[lld_pkg::CONF_DIM_EN_BIT];
      flagMode_q   <= lld_pkg::CONF_RESET[lld_pkg::CONF_FLAG_HI:lld_pkg::CONF_FLAG_LO];
      chanEn_q     <= '0;
      longPeriod_q <= lld_pkg::CONF_RESET[lld_pkg::UPPER_PERIOD_BIT];
      pwmOn_q      <= '0;
      gainPend_q   <= '0;
    end else if (regWrite) begin
      if (regAddr == lld_pkg::ADDR_CONF_ONE) begin
        busModeSel_q       <= regData[lld_pkg::CONF_BUS_MODE_BIT];
        flagMode_q         <= regData[lld_pkg::CONF_FLAG_HI:lld_pkg::CONF_FLAG_LO];
        dimEn_q            <= regData[lld_pkg::CONF_DIM_EN_BIT];
        chanEn_q[NUM_CH-1:8] <= regData[lld_pkg::CONF_CH_HI:0];
      end else if (regAddr == lld_pkg::ADDR_CONF_TWO) begin
        chanEn_q[7:0] <= regData;
      end else if (regAddr == lld_pkg::ADDR_UPPER_FAULT) begin
        longPeriod_q <= regData[lld_pkg::UPPER_PERIOD_BIT];
      end else if (regAddr >= lld_pkg::ADDR_GAIN_FIRST && regAddr <= lld_pkg::ADDR_GAIN_LAST) begin
        pwmOn_q[gainIdx[3:0]]    <= regData[lld_pkg::GAIN_PWM_ON_BIT];
        gainPend_q[gainIdx[3:0]] <= regData[GW-1:0];
      end
    end
  end

  logic dimActive;
  assign dimActive = busModeSel_q && dimEn_q;

  logic oscTick;

  lld_tick_gen #(
    .DIV (OSC_DIV)
  ) u_tick (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tick    (oscTick)
  );

  // Dimming counter: the 7-bit step count, each step lasting subTicks oscillator ticks.
  logic [SW-1:0] subTicks;
  logic [SW-1:0] subCnt_q;
  logic [GW-1:0] stepCnt_q;
  logic          stepEnd;
  logic          loadGains;

  assign subTicks  = longPeriod_q ? lld_pkg::SUB_LONG : lld_pkg::SUB_SHORT;
  assign stepEnd   = dimActive && oscTick && (subCnt_q >= subTicks - SUB_ONE);
  assign loadGains = stepEnd && (stepCnt_q == lld_pkg::STEP_LAST1);

  // Only a reset clears the count, so a re-entered period may start short.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      subCnt_q  <= '0;
      stepCnt_q <= '0;
    end else if (stepEnd) begin
      subCnt_q  <= '0;
      stepCnt_q <= stepCnt_q + STEP_ONE;
    end else if (dimActive && oscTick) begin
      subCnt_q <= subCnt_q + SUB_ONE;
    end
  end

  logic [NUM_CH-1:0][GW-1:0] gainAct_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gainAct_q <= '0;
    end else if (loadGains) begin
      gainAct_q <= gainPend_q;
    end
  end

  // On-time thresholds are refreshed channel by channel; a full sweep is far shorter
  // than the 7Fh step, so fresh gains are in place before the next period begins.
  logic [TW-1:0]             fullTicks;
  logic [TW-1:0]             position;
  logic [3:0]                engCh_q;
  logic                      engReady;
  logic                      engDone;
  logic [TW-1:0]             engResult;
  logic [NUM_CH-1:0][TW-1:0] thr_q;

  assign fullTicks = TW'(lld_pkg::STEPS) * TW'(subTicks);
  assign position  = TW'(stepCnt_q) * TW'(subTicks) + TW'(subCnt_q);

  lld_curve_engine #(
    .THR_W  (TW),
    .GAIN_W (GW)
  ) u_curve (
    .mclk    (mclk),
    .reset_n (reset_n),
    .start   (engReady),
    .gain    (gainAct_q[engCh_q]),
    .full    (fullTicks),
    .ready   (engReady),
    .done    (engDone),
    .result  (engResult)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      engCh_q <= '0;
      thr_q   <= '0;
    end else if (engDone) begin
      thr_q[engCh_q] <= engResult;
      engCh_q        <= (engCh_q == CH_LAST) ? 4'h0 : engCh_q + CH_ONE;
    end
  end

  // Staggered turn-on sequencer, paced by oscillator ticks.
  logic [lld_pkg::STG_W-1:0] stgCnt_q;
  logic                      stgRun_q;
  logic [NUM_CH-1:0]         latched_q;
  logic [NUM_CH-1:0]         pending;

  assign pending = chanEn_q & ~latched_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stgRun_q <= 1'b0;
      stgCnt_q <= '0;
    end else if (!dimActive || shutSync_q) begin
      stgRun_q <= 1'b0;
      stgCnt_q <= '0;
    end else if (!stgRun_q && pending != '0) begin
      stgRun_q <= 1'b1;
      stgCnt_q <= '0;
    end else if (stgRun_q && oscTick) begin
      if (stgCnt_q == lld_pkg::STAGGER_END) begin
        stgRun_q <= 1'b0;
      end else begin
        stgCnt_q <= stgCnt_q + STG_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      latched_q <= '0;
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        if (!chanEn_q[k] || !dimActive || shutSync_q) begin
          latched_q[k] <= 1'b0;
        end else if (stgRun_q && stgCnt_q >= lld_pkg::STAGGER_AT[k]) begin
          latched_q[k] <= 1'b1;
        end
      end
    end
  end

  // Output stage. A channel with its PWM bit off runs at full current.
  logic [NUM_CH-1:0] pwmLevel;
  logic [NUM_CH-1:0] chanOut_d;

  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      pwmLevel[k] = !pwmOn_q[k] || (position < thr_q[k]);
      if (shutSync_q || !chanEn_q[k]) begin
        chanOut_d[k] = 1'b0;
      end else if (dimActive) begin
        chanOut_d[k] = latched_q[k] && pwmLevel[k];
      end else begin
        chanOut_d[k] = 1'b1;
      end
    end
  end

  logic tAlert_q;
  logic tFail_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chanOut      <= '0;
      faultFlagPin <= 1'b0;
      tAlert_q     <= 1'b0;
      tFail_q      <= 1'b0;
    end else begin
      chanOut      <= chanOut_d;
      faultFlagPin <= shutSync_q;
      // A new event in the clearing cycle keeps the flag set.
      tAlert_q     <= warnSync_q || (tAlert_q && !statusClear);
      tFail_q      <= shutSync_q || (tFail_q && !statusClear);
    end
  end

  always_comb begin
    faultStatus                          = 8'h00;
    faultStatus[lld_pkg::STATUS_T_ALERT] = tAlert_q;
    faultStatus[lld_pkg::STATUS_T_FAIL]  = tFail_q;
  end

  assign flagMode = flagMode_q;
  assign dimCount = stepCnt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_shut_seen;
    shutSync_q ##1 1'b1;
  endsequence

  a_shut_outputs: assert property (s_shut_seen |-> (chanOut == '0 && faultFlagPin))
    else $error("outputs not off under thermal shutdown");

  a_warn_flag: assert property (warnSync_q |=> faultStatus[lld_pkg::STATUS_T_ALERT])
    else $error("thermal warning not flagged");

  a_counter_halt: assert property (!dimActive |=> $stable(stepCnt_q) && $stable(subCnt_q))
    else $error("dimming counter moved while halted");

  a_counter_resume: assert property ($rose(dimActive) |-> stepCnt_q == $past(stepCnt_q))
    else $error("dimming counter lost its value");

  a_gain_hold: assert property (!loadGains |=> $stable(gainAct_q))
    else $error("brightness changed away from step 7Fh");

  a_gain_load: assert property (loadGains
    |=> gainAct_q == $past(gainPend_q) && stepCnt_q == lld_pkg::STEP_MAX)
    else $error("brightness not loaded at step 7Fh");

  a_no_stagger: assert property ((!dimActive && !shutSync_q) |=> chanOut == $past(chanEn_q))
    else $error("outputs do not follow enables outside local dimming");

  a_stagger_gap: assert property ($rose(latched_q[6])
    |-> stgCnt_q >= lld_pkg::STAGGER_AT[6] && !$past(latched_q[6]))
    else $error("channel 6 turned on too early");

  a_pwm_compare: assert property ((dimActive && !shutSync_q && chanEn_q[0] && latched_q[0]
    && pwmOn_q[0]) |=> chanOut[0] == $past(position < thr_q[0]))
    else $error("channel 0 not following its on-time");

endmodule : lld_dimming

//--- bench/lld_host_model.sv
// Bus host model that writes the device registers one byte at a time.
`timescale 1ns/1ps
module lld_host_model (
  input  wire logic       mclk,
  output logic            regWrite,
  output logic      [7:0] regAddr,
  output logic      [7:0] regData
);
  initial begin
    regWrite = 1'b0;
    regAddr  = 8'h00;
    regData  = 8'h00;
  end

  // Address and data are inverted once the strobe drops, so late sampling reads garbage.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr  <= addr;
    regData  <= data;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAddr  <= ~addr;
    regData  <= ~data;
  endtask : write_reg

  task automatic write_conf(input logic [7:0] data);
    write_reg(lld_pkg::ADDR_CONF_ONE, data);
  endtask : write_conf

  task automatic write_gain(input int ch, input logic [7:0] data);
    write_reg(8'(int'(lld_pkg::ADDR_GAIN_FIRST) + ch), data);
  endtask : write_gain
endmodule : lld_host_model

//--- bench/lld_dimming_test.sv
// Self-checking bench for the local dimming PWM block.
`timescale 1ns/1ps
module lld_dimming_test;
  localparam int DIV = 9;

  logic        mclk         = 1'b0;
  logic        reset_n      = 1'b0;
  logic        statusClear  = 1'b0;
  logic        tempWarnRaw  = 1'b0;
  logic        tempShutRaw  = 1'b0;
  logic        regWrite;
  logic [7:0]  regAddr;
  logic [7:0]  regData;
  logic [11:0] chanOut;
  logic        faultFlagPin;
  logic [7:0]  faultStatus;
  logic [1:0]  flagMode;
  logic [6:0]  dimCount;
  logic [31:0] seed         = 32'h5B1A;
  int          failures     = 0;
  int          n_checks     = 0;
  int          pend[12];
  int          act[12];
  int          pwm[12];
  int          prevCount    = 0;

  always #4 mclk = ~mclk;

  lld_host_model host_u (.mclk(mclk), .regWrite(regWrite), .regAddr(regAddr), .regData(regData));

  lld_dimming #(.OSC_DIV(DIV)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .regWrite(regWrite), .regAddr(regAddr),
    .regData(regData), .statusClear(statusClear), .tempWarnRaw(tempWarnRaw),
    .tempShutRaw(tempShutRaw), .chanOut(chanOut), .faultFlagPin(faultFlagPin),
    .faultStatus(faultStatus), .flagMode(flagMode), .dimCount(dimCount));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Reference on-time in oscillator ticks, from the exponential law in integer steps.
  function automatic int on_ticks(input int g, input int sub);
    int t;
    t = lld_pkg::STEPS * sub;
    for (int j = g; j < lld_pkg::STEPS - 1; j++) t = t * lld_pkg::ALPHA_X10000 / 10000;
    return t;
  endfunction : on_ticks

  // Model output at the start of the current step; PWM off means full current.
  function automatic logic model_out(input int k, input int sub);
    if (pwm[k] == 0) return 1'b1;
    return (int'(dimCount) * sub) < on_ticks(act[k], sub);
  endfunction : model_out

  // Written brightness reaches the model only as the count enters 7Fh.
  always @(posedge mclk) begin
    if (reset_n === 1'b0) begin
      act  = '{default: 0};
      pend = '{default: 0};
    end else if (dimCount === lld_pkg::STEP_MAX && prevCount == int'(lld_pkg::STEP_LAST1)) begin
      act = pend;
    end
    prevCount = int'(dimCount);
  end

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      failures++;
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // Counts cycles until the dimming counter moves; running out of patience ends the run.
  task automatic wait_change(input int bound, output int cyc);
    logic [6:0] start;
    start = dimCount;
    for (cyc = 1; cyc <= bound; cyc++) begin
      step(1);
      if (dimCount !== start) return;
    end
    failures++;
    tally_and_finish();
  endtask : wait_change

  initial begin
    int         riseAt[8];
    int         offs[8];
    int         gaps[7] = '{1, 1, 1, 1, 2, 7, 1};
    int         subs[2];
    int         cyc;
    logic [6:0] held;
    logic [31:0] r;
    logic [11:0] want;
    logic [7:0] halts[2] = '{8'h8F, 8'h1F};
    subs[0] = int'(lld_pkg::SUB_SHORT);
    subs[1] = int'(lld_pkg::SUB_LONG);
    offs[0] = 0;
    for (int k = 1; k < 8; k++) offs[k] = offs[k-1] + gaps[k-1];
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    step(1);
    check(chanOut, 12'h000, "chan after reset");
    check(dimCount, 7'h00, "count after reset");
    for (int ch = 0; ch < 12; ch++) begin
      r = xs();
      host_u.write_gain(ch, {1'b0, r[6:0]});
      pend[ch] = int'(r[6:0]);
    end
    host_u.write_conf(8'h90);
    host_u.write_reg(8'h01, 8'hFF);
    for (int k = 0; k < 8; k++) riseAt[k] = -1;
    for (int c = 0; c < 300; c++) begin
      step(1);
      for (int k = 0; k < 8; k++) if (riseAt[k] < 0 && chanOut[k] === 1'b1) riseAt[k] = c;
    end
    check(riseAt[0] >= 0 && riseAt[0] <= riseAt[1], 1, "ch0 first");
    for (int k = 2; k < 8; k++) check(riseAt[k] - riseAt[1], (offs[k] - 1) * DIV, "stagger");
    host_u.write_conf(8'h9F);
    for (int p = 0; p < 2; p++) begin
      host_u.write_reg(lld_pkg::ADDR_UPPER_FAULT, p ? 8'h80 : 8'h00);
      wait_change(subs[p] * DIV + 50, cyc);
      wait_change(subs[p] * DIV + 50, cyc);
      check(cyc, subs[p] * DIV, "counter step length");
    end
    for (int i = 0; i < 2; i++) begin
      r = xs();
      host_u.write_conf(halts[i] | (r[7:0] & 8'h60));
      step(2);
      held = dimCount;
      step(subs[1] * DIV + 100);
      check(dimCount, held, "counter halted");
      check(flagMode, r[6:5], "flag mode");
      host_u.write_reg(8'h02, r[15:8]);
      host_u.write_reg(8'h20, r[23:16]);
      check(flagMode, r[6:5], "unmapped write");
      if (i == 0) begin
        host_u.write_reg(8'h01, 8'h00);
        step(4);
        check(chanOut[7:0], 8'h00, "disabled");
        host_u.write_reg(8'h01, 8'hFF);
        for (int c = 0; c < 20 && chanOut[7:0] === 8'h00; c++) step(1);
        check(chanOut[7:0], 8'hFF, "no stagger");
      end
      host_u.write_conf(8'h9F);
      wait_change(subs[1] * DIV + 50, cyc);
      check(dimCount, 7'(held + 7'h01), "resume");
    end
    host_u.write_gain(0, 8'hFF);
    r = xs();
    host_u.write_gain(1, {1'b1, r[6:0]});
    pwm[0]  = 1;
    pend[0] = int'(lld_pkg::STEP_MAX);
    pwm[1]  = 1;
    pend[1] = int'(r[6:0]);
    for (int n = 0; n < 3; n++) begin
      wait_change(subs[1] * DIV + 50, cyc);
      step(2);
      for (int k = 0; k < 12; k++) want[k] = model_out(k, subs[1]);
      check(chanOut, want, "pwm on-time");
    end
    host_u.write_conf(8'h8F);
    step(4);
    check(chanOut, 12'hFFF, "plain enable");
    @(posedge mclk) tempWarnRaw <= 1'b1;
    step(4);
    check({faultFlagPin, chanOut, faultStatus}, {1'b0, 12'hFFF, 8'h08}, "warning");
    @(posedge mclk) tempShutRaw <= 1'b1;
    step(4);
    check({faultFlagPin, chanOut, faultStatus}, {1'b1, 12'h000, 8'h0C}, "shutdown");
    @(posedge mclk) statusClear <= 1'b1;
    @(posedge mclk) statusClear <= 1'b0;
    step(2);
    check(faultStatus, 8'h0C, "clear refused");
    @(posedge mclk) begin
      tempWarnRaw <= 1'b0;
      tempShutRaw <= 1'b0;
    end
    step(4);
    check(faultFlagPin, 1'b0, "pin released");
    @(posedge mclk) statusClear <= 1'b1;
    @(posedge mclk) statusClear <= 1'b0;
    step(2);
    check(faultStatus, 8'h00, "status cleared");
    @(posedge mclk) reset_n <= 1'b0;
    step(2);
    check({chanOut, dimCount, flagMode}, 21'h0, "second reset");
    @(posedge mclk) reset_n <= 1'b1;
    step(2);
    tally_and_finish();
  end
endmodule : lld_dimming_test
